/* core/rdas_pkg.sv */
package rdas_pkg;

  // ***************************************************************
  // Register indices on the plain register port.
  // ***************************************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_OPTIONS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_SRC_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] REG_COUNTS = 4'h2;
  localparam logic [ADDR_W-1:0] REG_DST_ADDR = 4'h3;
  localparam logic [ADDR_W-1:0] REG_ARRAY_INDEX = 4'h4;
  localparam logic [ADDR_W-1:0] REG_BYTE_RELOAD = 4'h5;
  localparam logic [ADDR_W-1:0] REG_ARRAY_REF = 4'h6;
  localparam logic [ADDR_W-1:0] REG_READ_SPACING = 4'h7;

  // ***************************************************************
  // Option field positions and masks.
  // ***************************************************************
  localparam int OPT_CHAIN_BIT = 22;
  localparam int OPT_IRQ_BIT = 20;
  localparam int OPT_CODE_LSB = 12;
  localparam int OPT_FIFO_WIDTH_SELECT_LSB = 8;
  localparam int OPT_PRI_LSB = 4;
  localparam int OPT_DAM_BIT = 1;
  localparam int OPT_SAM_BIT = 0;
  // Writable option bits; reserved bits always read zero.
  localparam logic [31:0] OPT_RW_MASK = 32'h0053_f773;

  // ***************************************************************
  // Spacing codes and reset values.
  // ***************************************************************
  localparam logic [2:0] SPACING_MAX_CODE = 3'h4;
  localparam logic [2:0] FIFO_WIDTH_SELECT_MAX_CODE = 3'h5;
  localparam logic [5:0] SPACING_BASE = 6'h02;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] ZERO_HALF = 16'h0000;
  localparam logic [15:0] ONE_HALF = 16'h0001;

  // Submitted transfer request.
  typedef struct packed {
    logic [31:0] options;
    logic [31:0] src_addr;
    logic [15:0] array_count;
    logic [15:0] byte_count;
    logic [15:0] src_offset;
  } rdas_req_s;

  // Read command toward the endpoints.
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] bytes;
    logic [2:0] priority_lvl;
  } rdas_cmd_s;

  // Completion report toward the channel controller.
  typedef struct packed {
    logic [5:0] code;
    logic chain_en;
    logic irq_en;
  } rdas_done_s;

  typedef enum logic [1:0] {RDAS_IDLE, RDAS_WAIT, RDAS_ISSUE} rdas_state_e;

endpackage : rdas_pkg

/* core/rdas_top.sv */
`timescale 1ns/1ps
module rdas_top import rdas_pkg::*; #(
  parameter int BURST_BYTES = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Transfer request from the channel controller.
  input wire logic req_valid,
  input wire rdas_req_s req,
  output logic req_ready,
  // Read commands toward the endpoints.
  output logic cmd_valid,
  output rdas_cmd_s cmd,
  input wire logic cmd_ready,
  // Completion toward the channel controller.
  output logic done_valid,
  output rdas_done_s done
);

  // ***************************************************************
  // Active state.
  // ***************************************************************
  localparam logic [15:0] BURST = 16'(BURST_BYTES);
  rdas_state_e state_q;
  logic [31:0] opt_q;
  logic [31:0] src_q;
  logic [31:0] ref_q;
  logic [15:0] first_dim_byte_count_q;
  logic [15:0] array_count_q;
  logic [15:0] reload_q;
  logic [15:0] sidx_q;
  logic [2:0] spacing_q;
  logic [5:0] gap_q;
  logic [15:0] chunk;
  logic [31:0] fifo_bytes;
  logic [31:0] const_step;
  logic issue;
  logic last_chunk;
  logic last_array;
  // Top of the spacing counter; it only has to exceed the longest gap.
  localparam logic [5:0] SINCE_MAX = 6'h3f;
  logic [5:0] since_q;
  logic [5:0] gap_need;
  logic space_ok;
  logic take_req;
  logic empty_req;
  logic [31:0] next_ref;

  // Command size is the burst or the remainder of the array.
  assign chunk = (first_dim_byte_count_q < BURST) ? first_dim_byte_count_q : BURST;
  assign issue = (state_q == RDAS_ISSUE) && cmd_ready && cmd_valid;
  assign last_chunk = (first_dim_byte_count_q == chunk);
  assign last_array = (array_count_q <= ONE_HALF);
  // Constant mode wraps within the FIFO width, in bytes.
  assign fifo_bytes = ZERO_WORD + (32'h1 << opt_q[OPT_FIFO_WIDTH_SELECT_LSB +: 3]);

  // A request is taken only while idle, on the edge where both sides agree.
  assign take_req = (state_q == RDAS_IDLE) && req_valid && req_ready;
  // A request with no arrays or no bytes has nothing to read.
  assign empty_req = (req.array_count == ZERO_HALF) || (req.byte_count == ZERO_HALF);
  // Start of the next array; the offset is signed, so arrays may step back.
  assign next_ref = ref_q + {{16{sidx_q[15]}}, sidx_q};
  // Code n spaces accepted commands 2^(n+1) cycles apart. The two cycles of
  // the handshake itself are taken off, so code 0 gives back-to-back offers.
  assign gap_need = (SPACING_BASE << spacing_q) - SPACING_BASE;
  // Spacing is met once enough cycles have passed since the last command.
  assign space_ok = (since_q >= gap_need);

  // Offset of the next command within a constant-mode FIFO window.
  always_comb begin
    const_step = src_q - ref_q + 32'(chunk);
    if (const_step >= fifo_bytes) begin
      const_step = ZERO_WORD;
    end
  end

  // ***************************************************************
  // Sequencer.
  // ***************************************************************
  // Spacing: code n gives 2^(n+1) cycles, code 0 back to back.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= RDAS_IDLE;
      gap_q <= 6'h00;
    end else begin
      case (state_q)
        RDAS_IDLE: begin
          if (req_valid && req_ready) begin
            state_q <= (req.array_count == ZERO_HALF || req.byte_count == ZERO_HALF)
                       ? RDAS_IDLE : RDAS_ISSUE;
          end
        end
        RDAS_WAIT: begin
          if (gap_q <= 6'h01) begin
            state_q <= RDAS_ISSUE;
          end
          gap_q <= gap_q - 6'h01;
        end
        RDAS_ISSUE: begin
          if (issue) begin
            if (last_chunk && last_array) begin
              state_q <= RDAS_IDLE;
            end else if (spacing_q != 3'h0) begin
              state_q <= RDAS_WAIT;
              gap_q <= gap_need;
            end
          end
        end
        default: state_q <= RDAS_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // Active fields, one process for each, except the two remaining counts, which share one.
  // ***************************************************************
  // Options: loaded with reserved bits cleared, unchanged while reading.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opt_q <= ZERO_WORD;
    end else if (take_req) begin
      opt_q <= req.options & OPT_RW_MASK;
    end
  end

  // Source offset between arrays: loaded once, only read afterwards.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sidx_q <= ZERO_HALF;
    end else if (take_req) begin
      sidx_q <= req.src_offset;
    end
  end

  // Byte count reload: the programmed array length, kept for every array.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reload_q <= ZERO_HALF;
    end else if (take_req) begin
      reload_q <= req.byte_count;
    end
  end

  // Array start: moves by the signed offset when an array other than the last is finished.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_q <= ZERO_WORD;
    end else if (take_req) begin
      ref_q <= req.src_addr;
    end else if (issue && last_chunk && !last_array) begin
      ref_q <= next_ref;
    end
  end

  // Current source address: steps after every command, by mode.
  // The last command of a request leaves it where that command read, so
  // software can still see where the request ended.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_q <= ZERO_WORD;
    end else if (take_req) begin
      src_q <= req.src_addr;
    end else if (issue && !(last_chunk && last_array)) begin
      if (last_chunk) begin
        src_q <= next_ref;
      end else if (opt_q[OPT_SAM_BIT]) begin
        src_q <= ref_q + const_step;
      end else begin
        src_q <= src_q + 32'(chunk);
      end
    end
  end

  // Remaining counts. An empty request loads zeros, so its counts read as
  // finished at once; the last command of a request clears both as well.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_dim_byte_count_q <= ZERO_HALF;
      array_count_q <= ZERO_HALF;
    end else if (take_req) begin
      first_dim_byte_count_q <= empty_req ? ZERO_HALF : req.byte_count;
      array_count_q <= empty_req ? ZERO_HALF : req.array_count;
    end else if (issue) begin
      if (!last_chunk) begin
        first_dim_byte_count_q <= first_dim_byte_count_q - chunk;
      end else if (last_array) begin
        first_dim_byte_count_q <= ZERO_HALF;
        array_count_q <= ZERO_HALF;
      end else begin
        first_dim_byte_count_q <= reload_q;
        array_count_q <= array_count_q - ONE_HALF;
      end
    end
  end

  // Cycles since the last accepted command, held at its top value. The
  // spacing is global, so this also paces the first command of the next
  // request; the wait state alone only covers commands inside a request.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      since_q <= SINCE_MAX;
    end else if (issue) begin
      since_q <= 6'h00;
    end else if (since_q != SINCE_MAX) begin
      since_q <= since_q + 6'h01;
    end
  end

  // Global read spacing is software-writable at its own index.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      spacing_q <= 3'h0;
    end else if (reg_write && reg_addr == REG_READ_SPACING) begin
      spacing_q <= (reg_wdata[2:0] > SPACING_MAX_CODE) ? spacing_q : reg_wdata[2:0];
    end
  end

  // ***************************************************************
  // Outputs, all registered.
  // ***************************************************************
  // Request handshake: ready while idle, dropped for the cycle after a take.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state_q == RDAS_IDLE) && !take_req;
    end
  end

  // Command: offered once the spacing has run out, then held until taken.
  // An offer already standing is kept even if software raises the spacing,
  // so a command is never withdrawn before the endpoint takes it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_valid <= 1'b0;
      cmd <= '0;
    end else begin
      cmd_valid <= (state_q == RDAS_ISSUE) && !issue && (space_ok || cmd_valid);
      cmd.addr <= src_q;
      cmd.bytes <= chunk;
      cmd.priority_lvl <= opt_q[OPT_PRI_LSB +: 3];
    end
  end

  // Completion: one pulse after the last command, carrying the option bits
  // that tell the channel controller which flag to set.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_valid <= 1'b0;
      done <= '0;
    end else begin
      done_valid <= issue && last_chunk && last_array;
      done.code <= opt_q[OPT_CODE_LSB +: 6];
      done.chain_en <= opt_q[OPT_CHAIN_BIT];
      done.irq_en <= opt_q[OPT_IRQ_BIT];
    end
  end

  // ***************************************************************
  // Register read port; data stand one cycle after the strobe.
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= ZERO_WORD;
    end else if (reg_read) begin
      case (reg_addr)
        REG_OPTIONS: reg_rdata <= opt_q & OPT_RW_MASK;
        REG_SRC_ADDR: reg_rdata <= src_q;
        REG_COUNTS: reg_rdata <= {array_count_q, first_dim_byte_count_q};
        REG_DST_ADDR: reg_rdata <= ZERO_WORD;
        REG_ARRAY_INDEX: reg_rdata <= {ZERO_HALF, sidx_q};
        REG_BYTE_RELOAD: reg_rdata <= {ZERO_HALF, reload_q};
        REG_ARRAY_REF: reg_rdata <= ref_q;
        REG_READ_SPACING: reg_rdata <= {29'h0, spacing_q};
        default: reg_rdata <= ZERO_WORD;
      endcase
    end else begin
      reg_rdata <= ZERO_WORD;
    end
  end

endmodule : rdas_top

/* tb/rdas_cc.sv */
`timescale 1ns/1ps
module rdas_cc import rdas_pkg::*; (
  // Clock.
  input wire logic clk,
  // Bench side.
  input wire logic go,
  input wire rdas_req_s nreq,
  // Request port.
  input wire logic req_ready,
  output logic req_valid,
  output rdas_req_s req
);
  // Hold the offer until taken, then scramble it so a stale value cannot pass.
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  always @(posedge clk) begin
    if (go) begin
      req_valid <= 1'b1;
      req <= nreq;
    end else if (req_valid && req_ready) begin
      req_valid <= 1'b0;
      req <= ~req;
    end
  end
endmodule : rdas_cc

/* tb/rdas_sva.sv */
`timescale 1ns/1ps
module rdas_sva import rdas_pkg::*; #(
  parameter int BURST_BYTES = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports.
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic cmd_valid,
  input wire rdas_cmd_s cmd,
  input wire logic cmd_ready,
  input wire logic done_valid
);
  // ****
  // Checks.
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A command is taken only when both sides agree in one cycle.
  sequence cmd_take;
    cmd_valid && cmd_ready;
  endsequence
  rd_idle_a: assert property (!reg_read |=> reg_rdata == ZERO_WORD)
    else $error("read data not zero");
  dst_zero_a: assert property (
    reg_read && reg_addr == REG_DST_ADDR |=> reg_rdata == ZERO_WORD)
    else $error("dest address not zero");
  idx_high_a: assert property (
    reg_read && reg_addr == REG_ARRAY_INDEX |=> reg_rdata[31:16] == ZERO_HALF)
    else $error("index high half not zero");
  opt_rsvd_a: assert property (
    reg_read && reg_addr == REG_OPTIONS |=> (reg_rdata & ~OPT_RW_MASK) == ZERO_WORD)
    else $error("reserved option bits set");
  cmd_hold_a: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd))
    else $error("command changed while stalled");
  cmd_drop_a: assert property (cmd_take |=> !cmd_valid)
    else $error("command not dropped");
  burst_max_a: assert property (
    cmd_valid |-> cmd.bytes != ZERO_HALF && cmd.bytes <= BURST_BYTES)
    else $error("command size out of range");
  done_pulse_a: assert property (done_valid |=> !done_valid)
    else $error("done longer than one cycle");
  done_after_a: assert property (done_valid |-> $past(cmd_valid && cmd_ready))
    else $error("done without last command");
  ready_drop_a: assert property (req_valid && req_ready |=> !req_ready)
    else $error("ready stayed high");
endmodule : rdas_sva

bind rdas_top rdas_sva #(.BURST_BYTES(BURST_BYTES)) u_sva (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata), .req_valid(req_valid),
  .req_ready(req_ready), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .done_valid(done_valid));

/* tb/test_rdas_top.sv */
`timescale 1ns/1ps
module test_rdas_top import rdas_pkg::*;;
  // ****
  // Signals.
  // ****
  logic clk, rst_n, reg_write, reg_read, req_valid, req_ready, cmd_valid, cmd_ready;
  logic done_valid, go;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_rdata, reg_wdata;
  rdas_req_s req, nreq;
  rdas_cmd_s cmd;
  rdas_done_s done, edone;
  rdas_cmd_s eq[$];
  int failures = 0, n_tests = 0, ndone = 0;
  int cyc = 0, last_acc = -64, gap_min = 2;

  rdas_top #(.BURST_BYTES(16)) u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .done_valid(done_valid), .done(done));
  rdas_cc u_cc (.clk(clk), .go(go), .nreq(nreq), .req_ready(req_ready),
    .req_valid(req_valid), .req(req));

  // Clock at 50 ns.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic wrap_up;
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk({32'h0, reg_rdata}, {32'h0, e});
  endtask : rd

  // ****
  // Endpoint and result checks.
  // ****
  // The endpoint stalls at random so that held commands are exercised too.
  always @(posedge clk) begin
    cmd_ready <= $urandom_range(1) != 0;
    cyc++;
    if (cmd_valid && cmd_ready) begin
      chk(64'(cyc - last_acc >= gap_min), 64'h1);
      last_acc = cyc;
      if (eq.size() == 0) chk(64'h1, 64'h0);
      else chk({13'h0, cmd}, {13'h0, eq.pop_front()});
    end
    if (done_valid) begin
      ndone++;
      chk({56'h0, done}, {56'h0, edone});
    end
  end

  // The model walks arrays and bursts in either source mode; offsets are signed.
  task automatic xfer(input logic [31:0] o, s, input int na, nb, input logic [15:0] f);
    logic [31:0] a, st, lst;
    int b, c, ofs;
    st = s;
    lst = s;
    for (int i = 0; i < na; i++) begin
      a = st;
      b = nb;
      ofs = 0;
      if (nb > 0) lst = st;
      while (b > 0) begin
        c = (b < 16) ? b : 16;
        eq.push_back('{a, c[15:0], o[6:4]});
        // Constant mode returns to the array start at the FIFO width in bytes.
        ofs = (o[0] && ofs + c >= (1 << o[10:8])) ? 0 : ofs + c;
        a = st + ofs;
        b -= c;
      end
      st += {{16{f[15]}}, f};
    end
    edone = '{o[17:12], o[22], o[20]};
    nreq = '{o, s, na[15:0], nb[15:0], f};
    ndone = 0;
    for (int k = 0; k < 100 && req_ready !== 1'b1; k++) @(posedge clk);
    chk({63'h0, req_ready}, 64'h1);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int k = 0; k < 3000 && eq.size() > 0; k++) @(posedge clk);
    repeat (10) @(posedge clk);
    chk(64'(eq.size()), 64'h0);
    chk(64'(ndone), 64'(na * nb > 0));
    rd(REG_COUNTS, ZERO_WORD);
    rd(REG_OPTIONS, o & OPT_RW_MASK);
    rd(REG_ARRAY_INDEX, {16'h0, f});
    rd(REG_DST_ADDR, ZERO_WORD);
    rd(REG_BYTE_RELOAD, {16'h0, nb[15:0]});
    rd(REG_ARRAY_REF, lst);
  endtask : xfer

  // ****
  // Main sequence.
  // ****
  // Reset, register access, then transfers.
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    nreq = '0;
    cmd_ready = 1'b0;
    void'($urandom(86));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_OPTIONS, ZERO_WORD);
    wr(REG_COUNTS, 32'hffff_ffff);
    rd(REG_COUNTS, ZERO_WORD);
    wr(REG_READ_SPACING, 32'h1);
    wr(REG_READ_SPACING, 32'h5);
    rd(REG_READ_SPACING, 32'h1);
    wr(REG_READ_SPACING, 32'h0);
    rd(4'h8, ZERO_WORD);
    xfer(32'h0057_f7f2, 32'h1000_0000, 3, 16, 16'hfff0);
    xfer(32'h0, 32'h0, 2, 0, 16'h0);
    wr(REG_READ_SPACING, 32'h1);
    gap_min = 4;
    repeat (6) xfer($urandom, $urandom, $urandom_range(1, 3),
      $urandom_range(1, 40), 16'($urandom));
    wrap_up();
  end

  // A hang is cut short well past the expected run length.
  initial begin
    #1000000;
    failures++;
    wrap_up();
  end
endmodule : test_rdas_top
